// file: src/iid_interrupt_ident.v
/*
 * CPU-side interrupt level controller and identification search sequencer.
 * Holds the level enable and detect masks, internal trap detect and enable,
 * the running level, and drives the search level and chain into the bus.
 * Assumes bus request lines, code replies and control strobes are synchronous
 * to CLOCK, and that interfaces keep their own match flags and codes.
 */
`timescale 1ns/10ps
`include "iid_regs.vh"

module iid_interrupt_ident (
    input  wire        CLOCK,              // 250 MHz system clock
    input  wire        RESETN,             // Asynchronous reset, active low
    input  wire        ENABLE_WRITE,       // Load level enable mask
    input  wire [15:0] ENABLE_WDATA,       // New level enable mask
    input  wire        DETECT_WRITE,       // Load level detect mask
    input  wire [15:0] DETECT_WDATA,       // New level detect mask
    input  wire        TRAP_ENABLE_WRITE,  // Load internal trap enable
    input  wire [9:0]  TRAP_ENABLE_WDATA,  // New internal trap enable
    input  wire [9:0]  TRAP_REQUEST,       // Internal trap request pulses
    input  wire        TRAP_CLEAR,         // Clear selected trap detect bits
    input  wire [9:0]  TRAP_CLEAR_MASK,    // Trap detect bits to clear
    input  wire [4:0]  REQUEST_LINES,      // Bus lines for levels 10,11,12,13,15
    input  wire        IDENT_START,        // Start an identification search
    input  wire [3:0]  IDENT_LEVEL,        // Level named by the instruction
    input  wire        CODE_VALID,         // Stopping interface presents its code
    input  wire [15:0] CODE_DATA,          // Identification code from interface
    output reg  [15:0] LEVEL_ENABLE_MASK,  // Level enable mask
    output reg  [15:0] LEVEL_DETECT_MASK,  // Level detect mask
    output reg  [9:0]  TRAP_DETECT,        // Internal trap detect
    output reg  [9:0]  TRAP_ENABLE,        // Internal trap enable
    output wire [3:0]  CURRENT_LEVEL,      // Running level
    output wire        LEVEL_ACTIVE,       // Some enabled level is detected
    output reg         SEARCH_PRESENT,     // Searched level driven to interfaces
    output reg  [3:0]  SEARCH_LEVEL,       // Searched level value
    output reg         SEARCH_CHAIN,       // Chain signal into the nearest slot
    output reg         IDENT_BUSY,         // Search in progress
    output reg         IDENT_DONE,         // One-cycle search end pulse
    output reg         IDENT_FOUND,        // Last search got a code
    output reg         IDENT_ILLEGAL,      // Last search named a bad level
    output reg  [15:0] ACCUMULATOR         // Returned identification code
);

////////////////////////////////////////////////////////////////////////////////
// Level masks

    localparam [3:0] ST_IDLE     = 4'b0001;
    localparam [3:0] ST_PRESENT  = 4'b0010;
    localparam [3:0] ST_CHAIN    = 4'b0100;
    localparam [3:0] ST_WITHDRAW = 4'b1000;

    // Counts are reckoned from the 250 MHz clock; retune them if it changes
    localparam integer SETTLE_FULL = `IID_SETTLE_CYCLES;
    localparam integer REPLY_FULL  = `IID_REPLY_CYCLES;
    localparam [9:0]   SETTLE      = SETTLE_FULL[9:0];
    localparam [9:0]   REPLY       = REPLY_FULL[9:0];

    reg  [15:0] hw_levels;
    reg  [15:0] next_detect;
    reg  [9:0]  next_trap;

    always @* begin
        hw_levels = `IID_RESET_MASK;
        // Only 10-13 and 15 have lines; 0-9 stay software only
        hw_levels[`IID_HW_LINE_10] = REQUEST_LINES[0];  // [R3] [R1]
        hw_levels[`IID_HW_LINE_11] = REQUEST_LINES[1];  // [R3]
        hw_levels[`IID_HW_LINE_12] = REQUEST_LINES[2];  // [R3] [R8]
        hw_levels[`IID_HW_LINE_13] = REQUEST_LINES[3];  // [R3]
        hw_levels[`IID_HW_LINE_15] = REQUEST_LINES[4];  // [R3]
        // Trap requests reach level 14 only through their enables
        hw_levels[`IID_TRAP_LEVEL] = |(TRAP_DETECT & TRAP_ENABLE); // [R4]
        // A hardware request in the write cycle survives the write
        // Software must rewrite the detect mask to drop a served level
        next_detect = (DETECT_WRITE ? DETECT_WDATA : LEVEL_DETECT_MASK)
                      | hw_levels;                                 // [R1] [R2]
        next_trap = (TRAP_CLEAR ? (TRAP_DETECT & ~TRAP_CLEAR_MASK) : TRAP_DETECT)
                    | TRAP_REQUEST;                                // [R4]
    end

    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            LEVEL_ENABLE_MASK <= `IID_RESET_MASK;
            LEVEL_DETECT_MASK <= `IID_RESET_MASK;
            TRAP_DETECT       <= `IID_RESET_TRAP;
            TRAP_ENABLE       <= `IID_RESET_TRAP;
        end else begin
            if (ENABLE_WRITE) begin
                LEVEL_ENABLE_MASK <= ENABLE_WDATA;
            end
            if (TRAP_ENABLE_WRITE) begin
                TRAP_ENABLE <= TRAP_ENABLE_WDATA;
            end
            LEVEL_DETECT_MASK <= next_detect;
            TRAP_DETECT       <= next_trap;
        end
    end

    iid_level_select u_select (
        .clk         (CLOCK),
        .resetn      (RESETN),
        .enable_mask (LEVEL_ENABLE_MASK),
        .detect_mask (LEVEL_DETECT_MASK),
        .level       (CURRENT_LEVEL),
        .any_active  (LEVEL_ACTIVE)
    );

////////////////////////////////////////////////////////////////////////////////
// Identification search

    // One counter serves both the settle and the reply windows
    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [9:0]  count;
    reg  [9:0]  next_count;
    reg         next_present;
    reg  [3:0]  next_level;
    reg         next_chain;
    reg         next_busy;
    reg         next_done;
    reg         next_found;
    reg         next_illegal;
    reg  [15:0] next_accumulator;
    wire        count_last = (count == 10'h001);
    wire        level_ok   = (IDENT_LEVEL >= `IID_LOWEST_HW_LEVEL) &&
                             (IDENT_LEVEL <= `IID_HIGHEST_SEARCH);

    always @* begin
        next_state       = state;
        next_count       = count;
        next_present     = SEARCH_PRESENT;
        next_level       = SEARCH_LEVEL;
        next_chain       = SEARCH_CHAIN;
        next_busy        = IDENT_BUSY;
        next_done        = 1'b0;
        next_found       = IDENT_FOUND;
        next_illegal     = IDENT_ILLEGAL;
        next_accumulator = ACCUMULATOR;
        // Starts while busy are ignored; a search is never nested
        case (state)
            ST_IDLE: begin
                if (IDENT_START && level_ok) begin
                    // Only the named level is presented [R10] [R11]
                    next_present = 1'b1;
                    next_level   = IDENT_LEVEL;
                    next_busy    = 1'b1;
                    next_illegal = 1'b0;
                    next_count   = SETTLE;
                    next_state   = ST_PRESENT;
                end else if (IDENT_START) begin
                    next_illegal = 1'b1;                       // [R10]
                    next_found   = 1'b0;
                    next_done    = 1'b1;
                end
            end
            ST_PRESENT: begin
                // Give match flags time to settle before the chain runs
                if (count_last) begin
                    next_chain = 1'b1;                         // [R12] [R17]
                    next_count = REPLY;
                    next_state = ST_CHAIN;
                end else begin
                    next_count = count - 10'h001;
                end
            end
            ST_CHAIN: begin
                if (CODE_VALID) begin
                    next_accumulator = CODE_DATA;              // [R13]
                    next_found       = 1'b1;
                    next_state       = ST_WITHDRAW;
                end else if (count_last) begin
                    // No reply: nobody flagged, or a gap broke the chain
                    next_found = 1'b0;                         // [R16]
                    next_state = ST_WITHDRAW;
                end else begin
                    next_count = count - 10'h001;
                end
            end
            ST_WITHDRAW: begin
                // Dropping both ends the interfaces' match flags
                next_present = 1'b0;                           // [R21]
                next_chain   = 1'b0;
                next_level   = 4'h0;
                next_busy    = 1'b0;
                next_done    = 1'b1;
                next_state   = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

////////////////////////////////////////////////////////////////////////////////
// Search registers

    always @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state          <= ST_IDLE;
            count          <= 10'h000;
            SEARCH_PRESENT <= 1'b0;
            SEARCH_LEVEL   <= 4'h0;
            SEARCH_CHAIN   <= 1'b0;
            IDENT_BUSY     <= 1'b0;
            IDENT_DONE     <= 1'b0;
            IDENT_FOUND    <= 1'b0;
            IDENT_ILLEGAL  <= 1'b0;
            ACCUMULATOR    <= 16'h0000;
        end else begin
            // Every bus-facing output is a flip-flop of its own
            state          <= next_state;
            count          <= next_count;
            SEARCH_PRESENT <= next_present;
            SEARCH_LEVEL   <= next_level;
            SEARCH_CHAIN   <= next_chain;
            IDENT_BUSY     <= next_busy;
            IDENT_DONE     <= next_done;
            IDENT_FOUND    <= next_found;
            IDENT_ILLEGAL  <= next_illegal;
            ACCUMULATOR    <= next_accumulator;
        end
    end

endmodule

// file: src/iid_regs.vh
/*
 * Constants for the interrupt level controller and identification search.
 * Assumes one 250 MHz clock and that every input is synchronous to it.
 */
// Overview of operation
// R1: Levels 0 to 9 become active only through software detect-mask writes.
// R2: Levels 10 to 15 activate by software write or hardware request.
// R3: Bus lines for levels 10-13 and 15 feed the detect mask directly.
// R4: Level 14 is raised by latched traps gated by their trap enable bits.
// R5: Interfaces use level 10 PIO output, 11 DMA, 12 PIO input.
// R6: Level 13 is for real-time clocks and special PIO devices.
// R7: Level 15 outranks level 14, the power-failure level.
// R8: Many interfaces may share one line; the level only says something changed.
// R9: Each interface holds a switch-selected identification code unique to it.
// R10: A search examines only its named level, which must be 10 to 13.
// R11: Searched level is presented first; pending interfaces set a match flag.
// R12: Chain signal enters nearest slot; first flagged interface stops it.
// R13: The stopping interface returns its code; it lands in the accumulator.
// R14: Returning its code, the interface clears its channel interrupt enable.
// R15: The driver re-enables the channel interrupt enable after service.
// R16: An empty slot breaks the chain; interfaces beyond are never found.
// R17: Among requesters on one level, the slot nearest the CPU wins.
// R18: End-of-operation interrupt when ready status bit 3 and control bit 0 set.
// R19: Error interrupt when error status bit 4 and control bit 1 set.
// R20: Running level is the highest level set in enable and detect masks.
// R21: Match flag lasts one search; cleared when level and chain are withdrawn.
`ifndef IID_REGS_VH
`define IID_REGS_VH

`define IID_LEVELS          16
`define IID_TRAP_BITS       10
`define IID_CODE_BITS       16
`define IID_TRAP_LEVEL      4'he
`define IID_LOWEST_HW_LEVEL 4'ha
`define IID_HIGHEST_SEARCH  4'hd
`define IID_HW_LINE_10      10
`define IID_HW_LINE_11      11
`define IID_HW_LINE_12      12
`define IID_HW_LINE_13      13
`define IID_HW_LINE_15      15
`define IID_RESET_MASK      16'h0000
`define IID_RESET_TRAP      10'h000
`define IID_CLOCK_MHZ       250
`define IID_SETTLE_NS       40
`define IID_SETTLE_CYCLES   ((`IID_SETTLE_NS * `IID_CLOCK_MHZ + 999) / 1000)
`define IID_REPLY_NS        2000
`define IID_REPLY_CYCLES    ((`IID_REPLY_NS * `IID_CLOCK_MHZ) / 1000)
`define IID_COUNT_BITS      10

`endif

// file: src/iid_level_select.v
/*
 * Registered highest-priority selector for the running level.
 * Assumes the enable and detect masks come from flip-flops in the same domain.
 */
`timescale 1ns/10ps
`include "iid_regs.vh"

module iid_level_select (
    input  wire        clk,         // System clock
    input  wire        resetn,      // Asynchronous reset, active low
    input  wire [15:0] enable_mask, // Level enable mask
    input  wire [15:0] detect_mask, // Level detect mask
    output reg  [3:0]  level,       // Highest active level
    output reg         any_active   // Some level is both enabled and detected
);

////////////////////////////////////////////////////////////////////////////////

    wire [15:0] active = enable_mask & detect_mask;
    wire [3:0]  pick [0:16];

    // Upward scan so the highest set bit wins; level 15 above level 14
    assign pick[0] = 4'h0;
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : scan
            wire [31:0] idx = i;
            assign pick[i+1] = active[i] ? idx[3:0] : pick[i]; // [R20] [R7]
        end
    endgenerate

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level      <= 4'h0;
            any_active <= 1'b0;
        end else begin
            level      <= pick[16];
            any_active <= |active;
        end
    end

endmodule

// file: test/iid_asserts.sv
/* Checker for the running level and the identification search.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
module iid_asserts (
    input wire        CLOCK,             // Clock
    input wire        RESETN,            // Reset
    input wire [4:0]  REQUEST_LINES,     // Bus lines
    input wire        IDENT_START,       // Start
    input wire [3:0]  IDENT_LEVEL,       // Named level
    input wire        CODE_VALID,        // Reply
    input wire [15:0] CODE_DATA,         // Reply code
    input wire [15:0] LEVEL_ENABLE_MASK, // Enables
    input wire [15:0] LEVEL_DETECT_MASK, // Detects
    input wire [3:0]  CURRENT_LEVEL,     // Running level
    input wire        SEARCH_PRESENT,    // Level shown
    input wire [3:0]  SEARCH_LEVEL,      // Level value
    input wire        SEARCH_CHAIN,      // Chain
    input wire        IDENT_BUSY,        // Busy
    input wire        IDENT_DONE,        // Done
    input wire        IDENT_FOUND,       // Found
    input wire        IDENT_ILLEGAL,     // Bad level
    input wire [15:0] ACCUMULATOR        // Code
);
reg [3:0] hi;
integer   i;
wire      take  = IDENT_START && !IDENT_BUSY;
wire      legal = IDENT_LEVEL >= 4'ha && IDENT_LEVEL <= 4'hd;
always @* begin
    hi = 4'h0;
    for (i = 0; i < 16; i = i + 1) begin
        if (LEVEL_ENABLE_MASK[i] && LEVEL_DETECT_MASK[i]) begin
            hi = i[3:0];
        end
    end
end
default clocking cb @(posedge CLOCK); endclocking
default disable iff (!RESETN);
sequence settle;
    !SEARCH_CHAIN[*8] ##1 !SEARCH_CHAIN[*2] ##1 SEARCH_CHAIN;
endsequence
sequence withdrawn;
    IDENT_DONE && !SEARCH_PRESENT && !SEARCH_CHAIN && SEARCH_LEVEL == 4'h0;
endsequence
a_illegal_refused: assert property (take && !legal |=> IDENT_DONE && IDENT_ILLEGAL
    && !SEARCH_PRESENT) else $error("bad level not refused");
a_level_presented: assert property (take && legal |=> SEARCH_PRESENT && IDENT_BUSY
    && SEARCH_LEVEL == $past(IDENT_LEVEL)) else $error("level not presented");
a_chain_settles: assert property ($rose(SEARCH_PRESENT) |-> settle)
    else $error("chain timing wrong");
a_code_taken: assert property ($rose(CODE_VALID) && SEARCH_CHAIN |=> IDENT_FOUND
    && ACCUMULATOR == $past(CODE_DATA)) else $error("code not taken");
a_search_withdrawn: assert property ($fell(IDENT_BUSY) |-> withdrawn)
    else $error("search not withdrawn");
a_done_single: assert property (IDENT_DONE && !IDENT_START |=> !IDENT_DONE)
    else $error("done too long");
a_running_level: assert property ((LEVEL_ENABLE_MASK & LEVEL_DETECT_MASK) != 16'h0000
    |=> CURRENT_LEVEL == $past(hi)) else $error("running level wrong");
a_line_sets: assert property (REQUEST_LINES[2] |=> LEVEL_DETECT_MASK[12])
    else $error("line not detected");
endmodule
bind iid_interrupt_ident iid_asserts u_iid_asserts (.CLOCK(CLOCK), .RESETN(RESETN),
    .REQUEST_LINES(REQUEST_LINES), .IDENT_START(IDENT_START), .IDENT_LEVEL(IDENT_LEVEL),
    .CODE_VALID(CODE_VALID), .CODE_DATA(CODE_DATA), .LEVEL_ENABLE_MASK(LEVEL_ENABLE_MASK),
    .LEVEL_DETECT_MASK(LEVEL_DETECT_MASK), .CURRENT_LEVEL(CURRENT_LEVEL),
    .SEARCH_PRESENT(SEARCH_PRESENT), .SEARCH_LEVEL(SEARCH_LEVEL), .SEARCH_CHAIN(SEARCH_CHAIN),
    .IDENT_BUSY(IDENT_BUSY), .IDENT_DONE(IDENT_DONE), .IDENT_FOUND(IDENT_FOUND),
    .IDENT_ILLEGAL(IDENT_ILLEGAL), .ACCUMULATOR(ACCUMULATOR));

// file: test/iid_bus_model.sv
/* Four interface slots on the backplane, slot 0 nearest the CPU.
   Assumes the bench sets slot levels, fitted slots and reply delay. */
`timescale 1ns/10ps
module iid_bus_model (
    input  wire        clk,        // Clock
    input  wire        resetn,     // Reset, active low
    input  wire [15:0] slot_level, // Level per slot
    input  wire [3:0]  fitted,     // Slots in use
    input  wire [3:0]  set_enable, // Driver re-enables
    input  wire [3:0]  delay,      // Reply delay
    input  wire        present,    // Level shown
    input  wire [3:0]  level,      // Searched level
    input  wire        chain,      // Chain into slot 0
    output reg  [4:0]  lines,      // Request lines
    output reg         valid,      // Code returned
    output reg  [15:0] code        // Ident code
);
reg [3:0] enable, flag, count;
reg [2:0] stop;
reg       pass;
integer   i, j;
always @* begin
    lines = 5'h00;
    stop = 3'h4;
    pass = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
        // Enable stands for ready with control bit 0, or error with bit 1
        if (enable[i] && fitted[i] && slot_level[i*4+:4] == 4'hf) begin
            lines[4] = 1'b1;
        end else if (enable[i] && fitted[i]) begin
            lines[slot_level[i*4+:4] - 4'ha] = 1'b1;
        end
        if (pass && flag[i]) begin
            stop = i[2:0];
        end
        pass = pass && fitted[i] && !flag[i];
    end
end
always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        {enable, flag, count, valid, code} <= 29'h0000_0000;
    end else begin
        enable <= enable | set_enable;
        if (!valid) begin
            code <= ~code; // Undriven data must not look stable
        end
        if (!present) begin
            {flag, count, valid} <= 9'h000;
        end else if (!chain) begin
            for (j = 0; j < 4; j = j + 1) begin
                flag[j] <= enable[j] && fitted[j] && slot_level[j*4+:4] == level;
            end
        end else if (stop != 3'h4 && !valid) begin
            count <= count + 4'h1;
            if (count == delay) begin
                valid <= 1'b1;
                code <= 16'hc000 + stop; // Arbitrary code per slot
                enable[stop[1:0]] <= 1'b0;
            end
        end
    end
end
endmodule

// file: test/test_iid_interrupt_ident.sv
/* Self-checking bench for the level controller and identification search.
   Assumes the bus model stands for the interfaces on the backplane. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module test_iid_interrupt_ident;
reg        clock = 0, resetn = 0, en_wr = 0, det_wr = 0, te_wr = 0, t_clr = 0, start = 0;
reg [15:0] en_d = 0, det_d = 0, slots = 16'hdccb; // DMA, PIO input, clock slots
reg [9:0]  te_d = 0, t_req = 0, t_mask = 0;
reg [3:0]  lvl = 0, fitted = 4'hf, set_en = 0, delay = 0;
wire [15:0] en_m, det_m, code, acc;
wire [9:0]  t_det, t_en;
wire [4:0]  lines;
wire [3:0]  cur, s_lvl;
wire        act, s_pres, s_chain, busy, done, found, illegal, valid;
integer     mismatches = 0, check_count = 0, n;
always #2 clock = ~clock;
iid_interrupt_ident u_iid_interrupt_ident (.CLOCK(clock), .RESETN(resetn),
    .ENABLE_WRITE(en_wr), .ENABLE_WDATA(en_d), .DETECT_WRITE(det_wr), .DETECT_WDATA(det_d),
    .TRAP_ENABLE_WRITE(te_wr), .TRAP_ENABLE_WDATA(te_d), .TRAP_REQUEST(t_req),
    .TRAP_CLEAR(t_clr), .TRAP_CLEAR_MASK(t_mask), .REQUEST_LINES(lines), .IDENT_START(start),
    .IDENT_LEVEL(lvl), .CODE_VALID(valid), .CODE_DATA(code), .LEVEL_ENABLE_MASK(en_m),
    .LEVEL_DETECT_MASK(det_m), .TRAP_DETECT(t_det), .TRAP_ENABLE(t_en), .CURRENT_LEVEL(cur),
    .LEVEL_ACTIVE(act), .SEARCH_PRESENT(s_pres), .SEARCH_LEVEL(s_lvl), .SEARCH_CHAIN(s_chain),
    .IDENT_BUSY(busy), .IDENT_DONE(done), .IDENT_FOUND(found), .IDENT_ILLEGAL(illegal),
    .ACCUMULATOR(acc));
iid_bus_model u_iid_bus_model (.clk(clock), .resetn(resetn), .slot_level(slots),
    .fitted(fitted), .set_enable(set_en), .delay(delay), .present(s_pres), .level(s_lvl),
    .chain(s_chain), .lines(lines), .valid(valid), .code(code));
////////////////////////////////////////////////////////////////////////////////
task final_report;
    begin
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    end
endtask
task write_masks(input [15:0] en, input [15:0] det);
    begin
        @(posedge clock);
        {en_wr, det_wr, en_d, det_d} <= {2'b11, en, det};
        @(posedge clock);
        {en_wr, det_wr} <= 2'b00;
        repeat (3) @(posedge clock);
        #1;
    end
endtask
task ident(input [3:0] l, input f, input bad, input [15:0] c);
    begin
        @(posedge clock);
        {start, lvl} <= {1'b1, l};
        @(posedge clock);
        start <= 1'b0;
        #1;
        for (n = 0; n < 700 && done !== 1'b1; n = n + 1) begin
            @(posedge clock);
            #1;
        end
        `CHK("done", 1'b1, done)
        `CHK("found", f, found)
        `CHK("illegal", bad, illegal)
        if (f) `CHK("code", c, acc)
        repeat (2) @(posedge clock);
    end
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    #1;
    `CHK("detect reset", 16'h0000, det_m)
    write_masks(16'hffff, 16'h1c09);
    `CHK("enables", 16'hffff, en_m)
    `CHK("running", 4'hc, cur)
    `CHK("soft levels", 10'h009, det_m[9:0])
    @(posedge clock);
    {te_wr, te_d, t_req} <= {1'b1, 10'h004, 10'h004};
    @(posedge clock);
    {te_wr, t_req} <= 11'h000;
    repeat (3) @(posedge clock);
    #1;
    `CHK("trap detect", 10'h004, t_det)
    `CHK("trap enable", 10'h004, t_en)
    `CHK("trap level", 4'he, cur)
    @(posedge clock);
    {t_clr, t_mask} <= {1'b1, 10'h3ff};
    @(posedge clock);
    t_clr <= 1'b0;
    write_masks(16'hffff, 16'h0000);
    `CHK("trap cleared", 10'h000, t_det)
    `CHK("idle", 1'b0, act)
    $display("level test done");
    @(posedge clock);
    set_en <= 4'hf;
    @(posedge clock);
    set_en <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
    `CHK("hw lines", 4'he, det_m[13:10])
    ident(4'hc, 1, 0, 16'hc001);
    ident(4'hc, 1, 0, 16'hc002);
    ident(4'ha, 0, 0, 16'h0000);
    ident(4'h9, 0, 1, 16'h0000);
    ident(4'he, 0, 1, 16'h0000);
    delay <= 4'h6;
    ident(4'hd, 1, 0, 16'hc003);
    {fitted, set_en} <= 8'he2;
    @(posedge clock);
    set_en <= 4'h0;
    ident(4'hc, 0, 0, 16'h0000);
    fitted <= 4'hf;
    ident(4'hc, 1, 0, 16'hc001);
    {slots, set_en} <= {16'hfcca, 4'h9};
    @(posedge clock);
    set_en <= 4'h0;
    repeat (3) @(posedge clock);
    #1;
    `CHK("lines 15 10", 2'b11, {det_m[15], det_m[10]})
    `CHK("level 15", 4'hf, cur)
    ident(4'ha, 1, 0, 16'hc000);
    $display("search test done");
    final_report;
end
initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report;
end
endmodule
